/* rtl/pmw_clock_ctrl.sv */
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/10ps
`include "pmw_cfg.svh"

module pmw_clock_ctrl (
  input  wire logic                  clk_i,
  input  wire logic                  nrst_i,
  input  wire logic [7:0]            addr_i,
  input  wire logic [7:0]            wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  input  wire logic                  halt_i,
  input  wire logic                  wake_i,
  input  wire logic                  xtal_tick_i,
  input  wire logic                  fast_rc_tick_i,
  input  wire logic                  slow_rc_tick_i,
  input  wire logic                  wdt_timeout_i,
  input  wire logic                  clr_wdt_i,
  output logic [7:0]                 rdata_o,
  output logic                       cpu_run_o,
  output pmw_pkg::pmw_clk_sel_t      clk_sel_o,
  output pmw_pkg::pmw_osc_en_t       osc_en_o,
  output logic                       wdt_run_o,
  output logic                       wdt_clr_o,
  output logic                       tbase_en_o
);
  import pmw_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [2:0]  div_sel;             // Divider select field
  logic        fast_wakeup_enable;  // Fast wake-up control
  logic        idle_on_halt_select; // Halt goes to idle when set
  logic        high_low_clock_select;
  logic        idle_clock_keep_on;  // Idle keeps system clock
  logic        osc_is_fast_rc;      // 0 crystal, 1 internal fast RC
  logic        wdt_enable;          // Watchdog enabled
  logic        fast_osc_ready_flag;
  logic        slow_osc_ready_flag;
  logic        power_down_flag;
  logic        watchdog_timeout_flag;
  logic [10:0] settle_cnt;          // Fast oscillator settle count
  logic        wake_tick_seen;      // One edge of target clock seen
  pmw_state_t  state;
  pmw_state_t  next_state;
  pmw_state_t  wake_from;           // Low-power state left by wake
  logic        want_fast;           // Selection needs fast osc
  logic        run_state;           // CPU executing
  logic        halt_ok;             // Halt accepted this cycle
  logic        fast_tick;           // Tick of the chosen fast osc
  logic        target_tick;         // Tick of the wake target clock
  logic        next_fast_en;
  logic        next_slow_en;
  logic [10:0] settle_goal;

  // ----------------------------------------------------------------
  // Decode of the clock selection
  // ----------------------------------------------------------------
  // Slow RC only when select low and divider below 010
  assign want_fast   = high_low_clock_select | (div_sel >= `PMW_DIV_FIRST_FAST);
  assign run_state   = (state == ST_NORMAL) | (state == ST_SLOW) | (state == ST_FAST_WAKE);
  // Low-power entry exists only through halt
  assign halt_ok     = halt_i & run_state;
  assign fast_tick   = osc_is_fast_rc ? fast_rc_tick_i : xtal_tick_i;
  assign target_tick = want_fast ? fast_tick : slow_rc_tick_i;
  assign settle_goal = osc_is_fast_rc ? `PMW_INTERNAL_FAST_RC_OSC_SETTLE : `PMW_HXT_SETTLE;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      ST_NORMAL: begin
        // Leave for slow only once the slow RC is stable
        if (halt_ok) begin
          next_state = state;
        end else if (!want_fast && slow_osc_ready_flag) begin
          next_state = ST_SLOW;
        end
      end
      ST_SLOW: begin
        // Keep running slow until the fast osc reports ready
        if (want_fast && fast_osc_ready_flag && !halt_ok) begin
          next_state = ST_NORMAL;
        end
      end
      ST_FULL_STOP, ST_STOP_SLOW_RC, ST_IDLE_OFF, ST_IDLE_ON: begin
        if (wake_i) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // Crystal with fast wake: first slow RC edge starts the CPU
        if (want_fast && !osc_is_fast_rc && fast_wakeup_enable
            && (wake_from == ST_STOP_SLOW_RC || wake_from == ST_IDLE_OFF)
            && slow_osc_ready_flag && slow_rc_tick_i) begin
          next_state = ST_FAST_WAKE;
        end else if (wake_tick_seen && want_fast && fast_osc_ready_flag) begin
          next_state = ST_NORMAL;
        end else if (wake_tick_seen && !want_fast && slow_osc_ready_flag) begin
          next_state = ST_SLOW;
        end
      end
      ST_FAST_WAKE: begin
        if (fast_osc_ready_flag) begin
          next_state = ST_NORMAL;
        end
      end
      default: begin
        next_state = ST_WAKE;
      end
    endcase
    // Halt chooses the low-power state
    if (halt_ok) begin
      if (!idle_on_halt_select) begin
        next_state = wdt_enable ? ST_STOP_SLOW_RC : ST_FULL_STOP;
      end else begin
        next_state = idle_clock_keep_on ? ST_IDLE_ON : ST_IDLE_OFF;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register; power-on waits like a wake
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_WAKE;
    end else begin
      state <= next_state;
    end
  end

  // Remember the state left by the wake event
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_from <= ST_WAKE;
    end else if (state != ST_WAKE && next_state == ST_WAKE) begin
      wake_from <= state;
    end
  end

  // One edge of the target clock gives the 1~2 period wake delay
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wake_tick_seen <= 1'b0;
    end else if (state != ST_WAKE) begin
      wake_tick_seen <= 1'b0;
    end else if (target_tick) begin
      wake_tick_seen <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator enables
  // ----------------------------------------------------------------
  always_comb begin
    // Fast osc runs where it is, or will be, the system clock, and in normal even with a slow request
    case (next_state)
      ST_NORMAL, ST_WAKE, ST_FAST_WAKE: next_fast_en = want_fast;
      ST_SLOW:                          next_fast_en = want_fast;
      ST_IDLE_ON:                       next_fast_en = want_fast;
      default:                          next_fast_en = 1'b0;
    endcase
    // Normal with a slow request keeps fast osc until the switch
    if (next_state == ST_NORMAL) begin
      next_fast_en = 1'b1;
    end
    // Slow RC is off only in full stop
    next_slow_en = (next_state != ST_FULL_STOP);
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      osc_en_o <= '0;
    end else begin
      osc_en_o.fast_osc_en   <= next_fast_en;
      osc_en_o.periph_div_en <= next_fast_en;
      osc_en_o.slow_rc_en    <= next_slow_en;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator ready flags
  // ----------------------------------------------------------------
  // Counter restarts whenever the fast osc is stopped
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      settle_cnt          <= '0;
      fast_osc_ready_flag <= 1'b0;
    end else if (!osc_en_o.fast_osc_en) begin
      settle_cnt          <= '0;
      fast_osc_ready_flag <= 1'b0;
    end else if (fast_tick && !fast_osc_ready_flag) begin
      settle_cnt <= settle_cnt + 11'h001;
      if (settle_cnt + 11'h001 == settle_goal) begin
        fast_osc_ready_flag <= 1'b1;
      end
    end
  end

  // Slow RC ready after its first edge following start
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      slow_osc_ready_flag <= 1'b0;
    end else if (!osc_en_o.slow_rc_en) begin
      slow_osc_ready_flag <= 1'b0;
    end else if (slow_rc_tick_i) begin
      slow_osc_ready_flag <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Status flags: the set always wins over a clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      power_down_flag <= 1'b0;
    end else if (halt_ok) begin
      power_down_flag <= 1'b1;
    end else if (clr_wdt_i) begin
      power_down_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      watchdog_timeout_flag <= 1'b0;
    end else if (wdt_timeout_i) begin
      watchdog_timeout_flag <= 1'b1;
    end else if (halt_ok) begin
      watchdog_timeout_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes; low-power states never touch them
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {div_sel, fast_wakeup_enable} <= 4'h0;
      idle_on_halt_select           <= 1'b1;
      high_low_clock_select         <= 1'b1;
    end else if (wr_i && addr_i == `PMW_OFS_MODE) begin
      div_sel               <= wdata_i[`PMW_MODE_DIV_LSB +: 3];
      fast_wakeup_enable    <= wdata_i[`PMW_MODE_FAST_BIT];
      idle_on_halt_select   <= wdata_i[`PMW_MODE_IDLE_BIT];
      high_low_clock_select <= wdata_i[`PMW_MODE_HL_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      idle_clock_keep_on <= 1'b0;
      osc_is_fast_rc     <= 1'b0;
      wdt_enable         <= 1'b1;
    end else if (wr_i && addr_i == `PMW_OFS_CTRL) begin
      idle_clock_keep_on <= wdata_i[`PMW_CTRL_KEEP_BIT];
      osc_is_fast_rc     <= wdata_i[`PMW_CTRL_OSC_BIT];
      wdt_enable         <= wdata_i[`PMW_CTRL_WDT_BIT];
    end
  end

  // Read data one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `PMW_OFS_MODE: rdata_o <= {div_sel, fast_wakeup_enable, slow_osc_ready_flag,
                                   fast_osc_ready_flag, idle_on_halt_select,
                                   high_low_clock_select};
        `PMW_OFS_CTRL: rdata_o <= {5'h00, wdt_enable, osc_is_fast_rc, idle_clock_keep_on};
        `PMW_OFS_STAT: rdata_o <= {1'b0, state, 2'h0, watchdog_timeout_flag,
                                   power_down_flag};
        default:       rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Clock tree and CPU controls
  // ----------------------------------------------------------------
  // Memory, registers and ports hold simply because nothing clocks them
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cpu_run_o  <= 1'b0;
      clk_sel_o  <= '0;
      wdt_run_o  <= 1'b0;
      tbase_en_o <= 1'b0;
    end else begin
      cpu_run_o <= (next_state == ST_NORMAL) | (next_state == ST_SLOW)
                 | (next_state == ST_FAST_WAKE);
      clk_sel_o.undivided <= high_low_clock_select;
      clk_sel_o.div_sel   <= div_sel;
      case (next_state)
        ST_NORMAL, ST_IDLE_ON: clk_sel_o.src <= want_fast ? SRC_FAST : SRC_SLOW_RC;
        ST_SLOW, ST_FAST_WAKE: clk_sel_o.src <= SRC_SLOW_RC;
        default:               clk_sel_o.src <= SRC_OFF;
      endcase
      wdt_run_o  <= wdt_enable & (next_state != ST_FULL_STOP);
      tbase_en_o <= (next_state != ST_FULL_STOP) & (next_state != ST_STOP_SLOW_RC);
    end
  end

  // Watchdog counter clear pulse on halt entry
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wdt_clr_o <= 1'b0;
    end else begin
      wdt_clr_o <= halt_ok;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_full_stop_entry;
    halt_ok && !idle_on_halt_select && !wdt_enable |=> state == ST_FULL_STOP;
  endproperty
  a_full_stop_entry: assert property (p_full_stop_entry)
    else $error("halt with idle and watchdog off missed full stop");

  property p_full_stop_clocks;
    state == ST_FULL_STOP |-> !cpu_run_o && !wdt_run_o && !tbase_en_o
                             && clk_sel_o.src == SRC_OFF && !osc_en_o.slow_rc_en;
  endproperty
  a_full_stop_clocks: assert property (p_full_stop_clocks)
    else $error("clock still running in full stop");

  property p_wdt_clear;
    halt_ok |=> wdt_clr_o ##1 !wdt_clr_o;
  endproperty
  a_wdt_clear: assert property (p_wdt_clear)
    else $error("watchdog clear pulse wrong on halt");

  property p_halt_flags;
    halt_ok && !wdt_timeout_i |=> power_down_flag && !watchdog_timeout_flag;
  endproperty
  a_halt_flags: assert property (p_halt_flags)
    else $error("halt flags not updated");

  property p_idle_pick;
    halt_ok && idle_on_halt_select |=>
      state == (idle_clock_keep_on ? ST_IDLE_ON : ST_IDLE_OFF);
  endproperty
  a_idle_pick: assert property (p_idle_pick)
    else $error("halt picked wrong idle state");

  property p_slow_stops_fast;
    state == ST_SLOW && !want_fast && !$past(want_fast)
      |-> !osc_en_o.fast_osc_en && !osc_en_o.periph_div_en;
  endproperty
  a_slow_stops_fast: assert property (p_slow_stops_fast)
    else $error("fast oscillator left running in slow mode");

  property p_fast_wake_switch;
    state == ST_FAST_WAKE && fast_osc_ready_flag && !halt_ok
      |=> state == ST_NORMAL ##0 cpu_run_o;
  endproperty
  a_fast_wake_switch: assert property (p_fast_wake_switch)
    else $error("fast wake did not switch to crystal");

  property p_no_fast_from_stop;
    state == ST_WAKE && wake_from == ST_FULL_STOP |=> state != ST_FAST_WAKE;
  endproperty
  a_no_fast_from_stop: assert property (p_no_fast_from_stop)
    else $error("fast wake from full stop");

  property p_normal_ready;
    state == ST_NORMAL && $past(state) != ST_NORMAL |-> fast_osc_ready_flag;
  endproperty
  a_normal_ready: assert property (p_normal_ready)
    else $error("normal mode entered before fast osc ready");

  property p_slow_ready;
    state == ST_SLOW && $past(state) == ST_NORMAL |-> $past(slow_osc_ready_flag);
  endproperty
  a_slow_ready: assert property (p_slow_ready)
    else $error("slow mode entered before slow RC ready");

  c_fast_wake:  cover property (state == ST_WAKE ##1 state == ST_FAST_WAKE);
  c_full_stop:  cover property (state == ST_FULL_STOP ##[1:20] state == ST_WAKE);
  c_idle_wake:  cover property (state == ST_IDLE_ON ##1 state == ST_WAKE ##[1:40] cpu_run_o);
  c_slow_mode:  cover property (state == ST_NORMAL ##1 state == ST_SLOW);

endmodule // pmw_clock_ctrl

/* shared/pmw_cfg.svh */
// Overview of operation
// - Fast wake-up only from stop-with-slow-RC and idle-off
// - Fast wake-up enable bit gates the feature
// - Crystal fast wake runs slow RC until 1024
// - Fast RC 15-16 cycles, slow RC 1-2
// - Watchdog off: full stop wakes in 1024
// - Modes by select bits; sleep only by halt
// - Halt picks idle or sleep from two bits
// - Slow clock chosen stops fast oscillator, peripherals
// - Slow mode waits for slow-ready flag
// - Fast-ready flag only after oscillator stabilises
// - Full stop only on halt, idle=0, watchdog off
// - Full stop halts system, watchdog, time base clocks
// - Full stop keeps memory, registers, port states
// - Full stop clears and stops watchdog counter
// - Halt sets power-down, clears timeout flag
// - Idle keep-on low: clock off; high: running
// - Select=1 undivided fast; 0 divider field
`ifndef PMW_CFG_SVH
`define PMW_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define PMW_OFS_MODE        8'h00
`define PMW_OFS_CTRL        8'h04
`define PMW_OFS_STAT        8'h08

// ----------------------------------------------------------------
// Clock mode register fields
// ----------------------------------------------------------------
`define PMW_MODE_HL_BIT     0
`define PMW_MODE_IDLE_BIT   1
`define PMW_MODE_HRDY_BIT   2
`define PMW_MODE_LRDY_BIT   3
`define PMW_MODE_FAST_BIT   4
`define PMW_MODE_DIV_LSB    5
`define PMW_MODE_RST        8'h03

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define PMW_CTRL_KEEP_BIT   0
`define PMW_CTRL_OSC_BIT    1
`define PMW_CTRL_WDT_BIT    2
`define PMW_CTRL_RST        8'h04

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define PMW_STAT_PDF_BIT    0
`define PMW_STAT_TO_BIT     1
`define PMW_STAT_ST_LSB     4

// ----------------------------------------------------------------
// Divider codes and oscillator settle counts (oscillator cycles)
// ----------------------------------------------------------------
`define PMW_DIV_FIRST_FAST  3'h2
`define PMW_HXT_SETTLE      11'h400
`define PMW_INTERNAL_FAST_RC_OSC_SETTLE     11'h00f

`endif

/* shared/pmw_pkg.sv */
package pmw_pkg;

  // Controller states
  typedef enum logic [2:0] {
    ST_NORMAL,
    ST_SLOW,
    ST_FULL_STOP,
    ST_STOP_SLOW_RC,
    ST_IDLE_OFF,
    ST_IDLE_ON,
    ST_WAKE,
    ST_FAST_WAKE
  } pmw_state_t;

  // System clock source
  typedef enum logic [1:0] {
    SRC_OFF,
    SRC_FAST,
    SRC_SLOW_RC
  } pmw_src_t;

  // System clock selection towards the clock tree
  typedef struct packed {
    pmw_src_t   src;
    logic       undivided;
    logic [2:0] div_sel;
  } pmw_clk_sel_t;

  // Oscillator enables
  typedef struct packed {
    logic fast_osc_en;
    logic periph_div_en;
    logic slow_rc_en;
  } pmw_osc_en_t;

endpackage

/* tb/pmw_clock_ctrl_tb.sv */
`timescale 1ns/10ps

module pmw_clock_ctrl_tb;
  import pmw_pkg::*;

  logic clk_i, nrst_i, wr_i, rd_i, halt_i, wake_i, wdt_timeout_i, clr_wdt_i;
  logic [7:0] addr_i, wdata_i, rdata_o;
  logic xt, fr, sr, cpu_run_o, wdt_run_o, wdt_clr_o, tbase_en_o;
  pmw_clk_sel_t clk_sel_o;
  pmw_osc_en_t  osc_en_o;
  int fail_count = 0;
  int checked    = 0;
  int cnt;

  pmw_clock_ctrl pmw_clock_ctrl_inst (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .halt_i(halt_i), .wake_i(wake_i),
    .xtal_tick_i(xt), .fast_rc_tick_i(fr), .slow_rc_tick_i(sr),
    .wdt_timeout_i(wdt_timeout_i), .clr_wdt_i(clr_wdt_i), .rdata_o(rdata_o),
    .cpu_run_o(cpu_run_o), .clk_sel_o(clk_sel_o), .osc_en_o(osc_en_o),
    .wdt_run_o(wdt_run_o), .wdt_clr_o(wdt_clr_o), .tbase_en_o(tbase_en_o));

  pmw_osc_model pmw_osc_model_inst (.clk_i(clk_i), .nrst_i(nrst_i), .osc_en_i(osc_en_o),
    .xtal_tick_o(xt), .fast_rc_tick_o(fr), .slow_rc_tick_o(sr));

  // ----------------------------------------------------------
  // Clock, 25 MHz
  // ----------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------
  // Register bus cycles
  // ----------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;  // Read data stand only in this cycle
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(nm, exp, v);
  endtask

  // Poll the state field, bounded so a stuck switch cannot hang the run
  task automatic wait_state(input logic [2:0] st);
    logic [7:0] v;
    for (int i = 0; i < 1500; i++) begin
      rd(8'h08, v);
      if (v[6:4] === st) break;
    end
    chk("state", {5'h0, st}, {5'h0, v[6:4]});
  endtask

  // Halt, then look at outputs just after the edge that takes the halt,
  // while the one-cycle watchdog clear pulse still stands
  task automatic do_halt(input pmw_state_t st, input logic fast_on);
    @(posedge clk_i);
    halt_i <= 1'b1;
    @(posedge clk_i);
    halt_i <= 1'b0;
    #1 chk("halt_outs", {5'h0, 2'b10, fast_on},
           {5'h0, wdt_clr_o, cpu_run_o, osc_en_o.fast_osc_en});
    rd_chk("halt_stat", 8'h08, {1'b0, st, 4'h1});
  endtask

  // Wake and count cycles until the CPU may run
  task automatic do_wake();
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    cnt = 0;
    // Look at the run flag only once the edge's updates have settled
    #1;
    while (cpu_run_o !== 1'b1 && cnt < 3000) begin
      @(posedge clk_i);
      #1 cnt++;
    end
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    fail_count++;
    close_out();
  end

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    {nrst_i, wr_i, rd_i, halt_i, wake_i, wdt_timeout_i, clr_wdt_i} = '0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    do_wake();
    chk("por_wake", 8'h01, (cnt >= 1024 && cnt < 1100));
    rd_chk("mode_rst", 8'h00, 8'h0f);
    rd_chk("ctrl_rst", 8'h04, 8'h04);
    wr(8'h08, 8'hff);
    rd_chk("stat_ro", 8'h08, 8'h00);
    rd_chk("unmapped", 8'h0c, 8'h00);
    chk("undiv", 8'h01, {7'h0, clk_sel_o.undivided});
    // Slow mode and back through the divider field
    wr(8'h00, 8'h00);
    wait_state(ST_SLOW);
    chk("slow_src", SRC_SLOW_RC, clk_sel_o.src);
    chk("slow_osc", 8'h00, {6'h0, osc_en_o.fast_osc_en, osc_en_o.periph_div_en});
    wr(8'h00, 8'h40);
    wait_state(ST_NORMAL);
    rd_chk("mode_back", 8'h00, 8'h4c);
    chk("div_sel", 8'h02, {5'h0, clk_sel_o.div_sel});
    // Full stop: timeout flag set first, halt clears it
    @(posedge clk_i);
    wdt_timeout_i <= 1'b1;
    @(posedge clk_i);
    wdt_timeout_i <= 1'b0;
    rd_chk("to_set", 8'h08, 8'h02);
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h11);
    do_halt(ST_FULL_STOP, 1'b0);
    chk("stop_clks", 8'h00, {5'h0, tbase_en_o, wdt_run_o, osc_en_o.slow_rc_en});
    rd_chk("stop_mode", 8'h00, 8'h11);
    do_wake();
    chk("stop_wake", 8'h01, (cnt >= 1024 && cnt < 1100));
    @(posedge clk_i);
    clr_wdt_i <= 1'b1;
    @(posedge clk_i);
    clr_wdt_i <= 1'b0;
    rd_chk("pdf_clr", 8'h08, 8'h00);
    // Fast wake from stop with slow RC running
    wr(8'h04, 8'h04);
    do_halt(ST_STOP_SLOW_RC, 1'b0);
    do_wake();
    chk("fw_time", 8'h01, (cnt <= 20));
    #1 chk("fw_src", SRC_SLOW_RC, clk_sel_o.src);
    wait_state(ST_NORMAL);
    chk("fw_fast", SRC_FAST, clk_sel_o.src);
    // Idle with clock off, fast wake disabled
    wr(8'h00, 8'h03);
    do_halt(ST_IDLE_OFF, 1'b0);
    chk("idle_clock_off_state_src", SRC_OFF, clk_sel_o.src);
    do_wake();
    chk("idle_clock_off_state_wake", 8'h01, (cnt >= 1024 && cnt < 1100));
    // Idle with clock kept on
    wr(8'h04, 8'h05);
    do_halt(ST_IDLE_ON, 1'b1);
    do_wake();
    chk("idle_clock_on_state_wake", 8'h01, (cnt <= 4));
    // Fast RC source ignores fast wake
    wr(8'h04, 8'h06);
    wr(8'h00, 8'h11);
    do_halt(ST_STOP_SLOW_RC, 1'b0);
    do_wake();
    chk("rc_wake", 8'h01, (cnt >= 28 && cnt <= 40));
    #1 chk("rc_src", SRC_FAST, clk_sel_o.src);
    close_out();
  end
endmodule // pmw_clock_ctrl_tb

/* tb/pmw_osc_model.sv */
`timescale 1ns/10ps

// ------------------------------------------------------------
// Oscillator model: one tick per oscillator cycle while enabled
// ------------------------------------------------------------
module pmw_osc_model (
  input  wire logic                clk_i,
  input  wire logic                nrst_i,
  input  pmw_pkg::pmw_osc_en_t     osc_en_i,
  output logic                     xtal_tick_o,
  output logic                     fast_rc_tick_o,
  output logic                     slow_rc_tick_o
);
  import pmw_pkg::*;

  logic [2:0] phase;  // Free-running divider for the slower sources

  // Ticks stop dead with their enable, so a stopped source gives no settle progress
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase          <= 3'h0;
      xtal_tick_o    <= 1'b0;
      fast_rc_tick_o <= 1'b0;
      slow_rc_tick_o <= 1'b0;
    end else begin
      phase          <= phase + 3'h1;
      xtal_tick_o    <= osc_en_i.fast_osc_en;
      fast_rc_tick_o <= osc_en_i.fast_osc_en & phase[0];
      slow_rc_tick_o <= osc_en_i.slow_rc_en & (phase == 3'h7);
    end
  end
endmodule // pmw_osc_model
